// *** design/can_moa_regs.svh ***
// register offsets, field positions, reset values and counts of the message-object access block
`ifndef CAN_MOA_REGS_SVH
`define CAN_MOA_REGS_SVH
// register byte offsets
`define OFF_CMD_MASK 8'h00
`define OFF_MASK_LOW 8'h04
`define OFF_MASK_HIGH 8'h08
`define OFF_ARBIT_LOW 8'h0c
`define OFF_ARBIT_HIGH 8'h10
`define OFF_MSG_CTRL 8'h14
`define OFF_DATA_A_LOW 8'h18
`define OFF_DATA_A_HIGH 8'h1c
`define OFF_DATA_B_LOW 8'h20
`define OFF_DATA_B_HIGH 8'h24
`define OFF_CMD_REQ 8'h28
`define OFF_TX_REQ_SUM 8'h2c
`define OFF_NEW_DATA_SUM 8'h30
`define OFF_PEND_SUM 8'h34
// command mask bits
`define CM_WRITE 7
`define CM_MASK_SEL 6
`define CM_ARBIT_SEL 5
`define CM_CTRL_SEL 4
`define CM_CLR_PEND 3
`define CM_CLR_NEW 2
`define CM_DLO_SEL 1
`define CM_DHI_SEL 0
// message control bits
`define MC_NEW 15
`define MC_LOST 14
`define MC_PEND 13
`define MC_USE_MASK 12
`define MC_TX_IE 11
`define MC_RX_IE 10
`define MC_REMOTE_EN 9
`define MC_TX_REQ 8
`define MC_END_BUF 7
// arbitration high, mask high and command request busy bits
`define A2_VALID 15
`define A2_EXT 14
`define A2_DIR 13
`define M2_EXT 15
`define M2_DIR 14
`define CRQ_BUSY 15
// reset values and counts
`define IF_RESET 16'h0000
`define MAX_OBJ 32
`endif

// *** design/can_moa_pkg.sv ***
// types of the message-object access block
package can_moa_pkg;
  typedef enum logic [1:0] {XF_IDLE = 2'b00, XF_MOVE = 2'b01, XF_DONE = 2'b11} xfer_state_t;
  typedef struct packed {
    logic [15:0] msk1;
    logic [15:0] msk2;
    logic [15:0] arb1;
    logic [15:0] arb2;
    logic [15:0] ctl;
    logic [15:0] da1;
    logic [15:0] da2;
    logic [15:0] db1;
    logic [15:0] db2;
  } obj_t;
  typedef struct packed {
    logic [28:0] id;
    logic ext;
    logic remote;
    logic [3:0] dlc;
  } rx_hdr_t;
  typedef struct packed {
    logic [28:0] id;
    logic ext;
    logic [3:0] dlc;
    logic [63:0] data;
  } tx_frame_t;
endpackage

// *** design/can_message_object_access.sv ***
// message-object access path: interface registers, message store, tx pick and rx acceptance scan
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "can_moa_regs.svh"
module can_message_object_access import can_moa_pkg::*; #(
  parameter int NUM_OBJ = `MAX_OBJ
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transmit shift register side
  input wire logic tx_ready,
  input wire logic tx_done,
  input wire logic tx_fail,
  output logic tx_load,
  output logic [5:0] tx_obj,
  output tx_frame_t tx_frame,
  // receive shift register side
  input wire logic rx_valid,
  input wire rx_hdr_t rx_hdr,
  output logic rx_done,
  output logic rx_hit,
  output logic [5:0] rx_obj,
  // status
  output logic xfer_busy
);
  if (NUM_OBJ < 1 || NUM_OBJ > `MAX_OBJ) begin : g_bad_num
    $error("NUM_OBJ must lie between 1 and 32");
  end

  // ****************************************
  // interface registers and apb slave
  // ****************************************
  xfer_state_t state_ff, nxt_state;
  obj_t if_ff, nxt_if;
  obj_t obj_ff [NUM_OBJ];
  obj_t nxt_obj [NUM_OBJ];
  obj_t xobj;
  logic [15:0] cmask_ff, nxt_cmask;
  logic [5:0] crq_ff, nxt_crq;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic busy_ff, nxt_busy;
  logic [NUM_OBJ-1:0] txrq_ff, nxt_txrq, new_ff, nxt_new, pend_ff, nxt_pend, lost_ff, nxt_lost;
  logic [4:0] xidx;
  logic acc;
  logic bad_addr;
  logic [31:0] rd_val;

  assign xidx = 5'(crq_ff - 6'h01);
  assign xobj = obj_ff[xidx];
  assign acc = psel & penable & pready_ff;

  // read mux and unmapped-address decode
  always_comb begin
    rd_val = 32'h0;
    bad_addr = 1'b0;
    case (paddr)
      `OFF_CMD_MASK: rd_val = {16'h0, cmask_ff};
      `OFF_MASK_LOW: rd_val = {16'h0, if_ff.msk1};
      `OFF_MASK_HIGH: rd_val = {16'h0, if_ff.msk2};
      `OFF_ARBIT_LOW: rd_val = {16'h0, if_ff.arb1};
      `OFF_ARBIT_HIGH: rd_val = {16'h0, if_ff.arb2};
      `OFF_MSG_CTRL: rd_val = {16'h0, if_ff.ctl};
      `OFF_DATA_A_LOW: rd_val = {16'h0, if_ff.da1};
      `OFF_DATA_A_HIGH: rd_val = {16'h0, if_ff.da2};
      `OFF_DATA_B_LOW: rd_val = {16'h0, if_ff.db1};
      `OFF_DATA_B_HIGH: rd_val = {16'h0, if_ff.db2};
      `OFF_CMD_REQ: rd_val = {16'h0, busy_ff, 9'h0, crq_ff};
      `OFF_TX_REQ_SUM: rd_val = 32'(txrq_ff);
      `OFF_NEW_DATA_SUM: rd_val = 32'(new_ff);
      `OFF_PEND_SUM: rd_val = 32'(pend_ff);
      default: bad_addr = 1'b1;
    endcase
  end

  // apb answer, register writes and transfer sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_if = if_ff;
    nxt_cmask = cmask_ff;
    nxt_crq = crq_ff;
    nxt_pready = psel & penable & ~pready_ff; // one wait state
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (psel && penable && !pready_ff) begin
      nxt_prdata = pwrite ? 32'h0 : rd_val;
      nxt_pslverr = bad_addr;
    end
    if (acc && pwrite && !pslverr_ff && !busy_ff) begin
      case (paddr)
        `OFF_CMD_MASK: nxt_cmask = pwdata[15:0];
        `OFF_MASK_LOW: nxt_if.msk1 = pwdata[15:0];
        `OFF_MASK_HIGH: nxt_if.msk2 = pwdata[15:0];
        `OFF_ARBIT_LOW: nxt_if.arb1 = pwdata[15:0];
        `OFF_ARBIT_HIGH: nxt_if.arb2 = pwdata[15:0];
        `OFF_MSG_CTRL: nxt_if.ctl = pwdata[15:0];
        `OFF_DATA_A_LOW: nxt_if.da1 = pwdata[15:0];
        `OFF_DATA_A_HIGH: nxt_if.da2 = pwdata[15:0];
        `OFF_DATA_B_LOW: nxt_if.db1 = pwdata[15:0];
        `OFF_DATA_B_HIGH: nxt_if.db2 = pwdata[15:0];
        `OFF_CMD_REQ: begin
          if (pwdata[5:0] != 6'h00 && pwdata[5:0] <= 6'(NUM_OBJ)) begin
            nxt_crq = pwdata[5:0];
            nxt_state = XF_MOVE;
          end
        end
        default: ;
      endcase
    end
    unique case (state_ff)
      XF_IDLE: ;
      XF_MOVE: begin
        if (!cmask_ff[`CM_WRITE]) begin
          if (cmask_ff[`CM_MASK_SEL]) begin
            nxt_if.msk1 = xobj.msk1;
            nxt_if.msk2 = xobj.msk2;
          end
          if (cmask_ff[`CM_ARBIT_SEL]) begin
            nxt_if.arb1 = xobj.arb1;
            nxt_if.arb2 = xobj.arb2;
          end
          if (cmask_ff[`CM_CTRL_SEL]) begin
            nxt_if.ctl = {new_ff[xidx], lost_ff[xidx], pend_ff[xidx], xobj.ctl[12:9], txrq_ff[xidx], xobj.ctl[7:0]};
          end
          if (cmask_ff[`CM_DLO_SEL]) begin
            nxt_if.da1 = xobj.da1;
            nxt_if.da2 = xobj.da2;
          end
          if (cmask_ff[`CM_DHI_SEL]) begin
            nxt_if.db1 = xobj.db1;
            nxt_if.db2 = xobj.db2;
          end
        end
        nxt_state = XF_DONE;
      end
      XF_DONE: nxt_state = XF_IDLE;
    endcase
    nxt_busy = (nxt_state != XF_IDLE);
  end

  // interface register flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= XF_IDLE;
      if_ff <= '0;
      cmask_ff <= `IF_RESET;
      crq_ff <= 6'h01;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      if_ff <= nxt_if;
      cmask_ff <= nxt_cmask;
      crq_ff <= nxt_crq;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      busy_ff <= nxt_busy;
    end
  end

  // ****************************************
  // message store, transmit pick, receive scan
  // ****************************************
  logic tx_active_ff, nxt_tx_active, dirty_ff, nxt_dirty;
  logic [4:0] tx_idx_ff, nxt_tx_idx, pick_idx, match_idx;
  logic pick_found, match_found, wr_now;
  logic tx_load_ff, nxt_tx_load, rx_done_ff, nxt_rx_done, rx_hit_ff, nxt_rx_hit;
  logic [5:0] tx_obj_ff, nxt_tx_obj, rx_obj_ff, nxt_rx_obj;
  tx_frame_t tx_frame_ff, nxt_tx_frame;
  logic [NUM_OBJ-1:0] eligible;

  // acceptance compare of one object against an incoming header
  function automatic logic obj_match(input obj_t o, input rx_hdr_t h);
    logic [28:0] oid;
    logic [28:0] m;
    logic use_m;
    logic ok;
    use_m = o.ctl[`MC_USE_MASK];
    if (h.ext) begin
      oid = {o.arb2[12:0], o.arb1};
      m = use_m ? {o.msk2[12:0], o.msk1} : {29{1'b1}};
    end else begin
      oid = {18'h0, o.arb2[12:2]};
      m = use_m ? {18'h0, o.msk2[12:2]} : {18'h0, 11'h7ff};
    end
    ok = o.arb2[`A2_VALID] && (((oid ^ h.id) & m) == 29'h0);
    if (!use_m || o.msk2[`M2_EXT]) ok = ok && (o.arb2[`A2_EXT] == h.ext);
    if (!use_m || o.msk2[`M2_DIR]) ok = ok && (o.arb2[`A2_DIR] == h.remote);
    return ok;
  endfunction

  // pending, valid transmit objects; lowest number wins
  always_comb begin
    pick_found = 1'b0;
    pick_idx = 5'h00;
    match_found = 1'b0;
    match_idx = 5'h00;
    for (int i = NUM_OBJ - 1; i >= 0; i--) begin
      eligible[i] = txrq_ff[i] & obj_ff[i].arb2[`A2_VALID] & obj_ff[i].arb2[`A2_DIR];
      if (eligible[i]) begin
        pick_found = 1'b1;
        pick_idx = 5'(i);
      end
      if (obj_match(obj_ff[i], rx_hdr)) begin
        match_found = 1'b1;
        match_idx = 5'(i);
      end
    end
  end

  // next values of the message store and both engines
  always_comb begin
    nxt_obj = obj_ff;
    nxt_txrq = txrq_ff;
    nxt_new = new_ff;
    nxt_pend = pend_ff;
    nxt_lost = lost_ff;
    nxt_tx_active = tx_active_ff;
    nxt_tx_idx = tx_idx_ff;
    nxt_dirty = dirty_ff;
    nxt_tx_load = 1'b0;
    nxt_tx_obj = tx_obj_ff;
    nxt_tx_frame = tx_frame_ff;
    nxt_rx_done = 1'b0;
    nxt_rx_hit = 1'b0;
    nxt_rx_obj = rx_obj_ff;
    wr_now = (state_ff == XF_MOVE) && cmask_ff[`CM_WRITE];
    // transfer into the object; no valid or request gating so data updates run any time
    if (wr_now) begin
      if (cmask_ff[`CM_MASK_SEL]) begin
        nxt_obj[xidx].msk1 = if_ff.msk1;
        nxt_obj[xidx].msk2 = if_ff.msk2;
      end
      if (cmask_ff[`CM_ARBIT_SEL]) begin
        nxt_obj[xidx].arb1 = if_ff.arb1;
        nxt_obj[xidx].arb2 = if_ff.arb2;
      end
      if (cmask_ff[`CM_CTRL_SEL]) begin
        nxt_obj[xidx].ctl = if_ff.ctl;
        nxt_new[xidx] = if_ff.ctl[`MC_NEW];
        nxt_lost[xidx] = if_ff.ctl[`MC_LOST];
        nxt_pend[xidx] = if_ff.ctl[`MC_PEND];
        nxt_txrq[xidx] = if_ff.ctl[`MC_TX_REQ];
      end
      if (cmask_ff[`CM_DLO_SEL]) begin
        nxt_obj[xidx].da1 = if_ff.da1;
        nxt_obj[xidx].da2 = if_ff.da2;
      end
      if (cmask_ff[`CM_DHI_SEL]) begin
        nxt_obj[xidx].db1 = if_ff.db1;
        nxt_obj[xidx].db2 = if_ff.db2;
      end
      if (tx_active_ff && xidx == tx_idx_ff) nxt_dirty = 1'b1;
    end
    if (state_ff == XF_MOVE) begin
      if (cmask_ff[`CM_CLR_PEND]) nxt_pend[xidx] = 1'b0;
      if (cmask_ff[`CM_CLR_NEW] && !(wr_now && cmask_ff[`CM_CTRL_SEL])) nxt_new[xidx] = 1'b0;
    end
    // end of a transmission; a write in flight counts as new data
    if (tx_active_ff && (tx_done || tx_fail)) begin
      nxt_tx_active = 1'b0;
      if (tx_done) begin
        if (!dirty_ff && !(wr_now && xidx == tx_idx_ff)) nxt_txrq[tx_idx_ff] = 1'b0;
        if (obj_ff[tx_idx_ff].ctl[`MC_TX_IE]) nxt_pend[tx_idx_ff] = 1'b1;
      end
    end
    // load the shift register only while no interface transfer runs
    if (state_ff == XF_IDLE && tx_ready && !tx_active_ff && pick_found) begin
      nxt_tx_active = 1'b1;
      nxt_tx_idx = pick_idx;
      nxt_dirty = 1'b0;
      nxt_new[pick_idx] = 1'b0;
      nxt_tx_load = 1'b1;
      nxt_tx_obj = 6'(pick_idx) + 6'h01;
      nxt_tx_frame.ext = obj_ff[pick_idx].arb2[`A2_EXT];
      nxt_tx_frame.id = obj_ff[pick_idx].arb2[`A2_EXT] ? {obj_ff[pick_idx].arb2[12:0], obj_ff[pick_idx].arb1}
                                                      : {18'h0, obj_ff[pick_idx].arb2[12:2]};
      nxt_tx_frame.dlc = obj_ff[pick_idx].ctl[3:0];
      nxt_tx_frame.data = {obj_ff[pick_idx].db2, obj_ff[pick_idx].db1,
                           obj_ff[pick_idx].da2, obj_ff[pick_idx].da1};
    end
    // acceptance scan result; a remote frame may raise the request
    if (rx_valid) begin
      nxt_rx_done = 1'b1;
      nxt_rx_hit = match_found;
      nxt_rx_obj = match_found ? 6'(match_idx) + 6'h01 : 6'h00;
      if (match_found && rx_hdr.remote && obj_ff[match_idx].arb2[`A2_DIR]
          && obj_ff[match_idx].ctl[`MC_REMOTE_EN]) begin
        nxt_txrq[match_idx] = 1'b1;
      end
    end
  end

  // message store and engine flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obj_ff <= '{default: '0};
      txrq_ff <= '0;
      new_ff <= '0;
      pend_ff <= '0;
      lost_ff <= '0;
      tx_active_ff <= 1'b0;
      tx_idx_ff <= 5'h00;
      dirty_ff <= 1'b0;
      tx_load_ff <= 1'b0;
      tx_obj_ff <= 6'h00;
      tx_frame_ff <= '0;
      rx_done_ff <= 1'b0;
      rx_hit_ff <= 1'b0;
      rx_obj_ff <= 6'h00;
    end else if (ce) begin
      obj_ff <= nxt_obj;
      txrq_ff <= nxt_txrq;
      new_ff <= nxt_new;
      pend_ff <= nxt_pend;
      lost_ff <= nxt_lost;
      tx_active_ff <= nxt_tx_active;
      tx_idx_ff <= nxt_tx_idx;
      dirty_ff <= nxt_dirty;
      tx_load_ff <= nxt_tx_load;
      tx_obj_ff <= nxt_tx_obj;
      tx_frame_ff <= nxt_tx_frame;
      rx_done_ff <= nxt_rx_done;
      rx_hit_ff <= nxt_rx_hit;
      rx_obj_ff <= nxt_rx_obj;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign tx_load = tx_load_ff;
  assign tx_obj = tx_obj_ff;
  assign tx_frame = tx_frame_ff;
  assign rx_done = rx_done_ff;
  assign rx_hit = rx_hit_ff;
  assign rx_obj = rx_obj_ff;
  assign xfer_busy = busy_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [NUM_OBJ-1:0] below_pick;
  assign below_pick = NUM_OBJ'((64'h1 << pick_idx) - 64'h1);

  a_busy_blocks_write: assert property (ce && busy_ff && acc && pwrite && paddr == `OFF_MASK_LOW
    |=> if_ff.msk1 == $past(if_ff.msk1)) else $error("interface write taken while busy");
  a_start_sets_busy: assert property (ce && !busy_ff && acc && pwrite && !pslverr_ff
    && paddr == `OFF_CMD_REQ && pwdata[5:0] == 6'h01 |=> busy_ff ##1 (!ce || state_ff == XF_DONE))
    else $error("command request did not start a transfer");
  a_tx_lowest: assert property (ce && nxt_tx_load |-> (eligible & below_pick) == '0)
    else $error("lower numbered pending object skipped");
  a_load_clears_new: assert property (ce && nxt_tx_load |=> !new_ff[tx_idx_ff])
    else $error("new-data not cleared at transmission start");
  a_done_clears_req: assert property (ce && tx_done && tx_active_ff && !dirty_ff && !wr_now && !rx_valid
    |=> !txrq_ff[tx_idx_ff]) else $error("request not cleared after success");
  a_dirty_keeps_req: assert property (ce && tx_done && tx_active_ff && dirty_ff && txrq_ff[tx_idx_ff]
    |=> txrq_ff[tx_idx_ff]) else $error("request lost although new data was written");
  a_done_sets_pend: assert property (ce && tx_done && tx_active_ff && obj_ff[tx_idx_ff].ctl[`MC_TX_IE]
    |=> pend_ff[$past(tx_idx_ff)]) else $error("pending not set after transmission");
  a_remote_sets_req: assert property (ce && rx_valid && rx_hdr.remote && match_found
    && obj_ff[match_idx].ctl[`MC_REMOTE_EN] && obj_ff[match_idx].arb2[`A2_DIR]
    |=> txrq_ff[$past(match_idx)] && rx_hit_ff) else $error("remote frame did not raise request");
  a_clear_pend: assert property (ce && state_ff == XF_MOVE && cmask_ff[`CM_CLR_PEND] && !tx_active_ff
    |=> !pend_ff[$past(xidx)]) else $error("pending not cleared by transfer");
  a_clear_new: assert property (ce && state_ff == XF_MOVE && cmask_ff[`CM_CLR_NEW] && !cmask_ff[`CM_CTRL_SEL]
    |=> !new_ff[$past(xidx)]) else $error("new-data not cleared by transfer");
  a_write_data: assert property (ce && wr_now && cmask_ff[`CM_DLO_SEL]
    |=> obj_ff[$past(xidx)].da1 == $past(if_ff.da1)) else $error("data half not written");
  a_read_arbit: assert property (ce && state_ff == XF_MOVE && !cmask_ff[`CM_WRITE] && cmask_ff[`CM_ARBIT_SEL]
    |=> if_ff.arb2 == $past(xobj.arb2)) else $error("arbitration group not read");
  a_scan_result: assert property (ce && rx_valid |=> rx_done_ff && rx_hit_ff == $past(match_found))
    else $error("scan result wrong");
  c_tx_load: cover property (tx_load_ff);
  c_remote_hit: cover property (rx_hit_ff && txrq_ff != '0);
  c_write_xfer: cover property (wr_now ##2 !busy_ff);
  c_dirty_done: cover property (tx_done && dirty_ff);
endmodule

// *** tb/can_tx_shift_model.sv ***
// transmit shift register stand-in that loads frames and reports success
`timescale 1ns/1ps
module can_tx_shift_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench control: run gates readiness, delay sets frame length
  input wire logic run,
  input wire logic [3:0] delay,
  // shift register side
  input wire logic tx_load,
  output logic tx_ready,
  output logic tx_done,
  output logic tx_fail
);
  logic busy_ff;
  logic [3:0] cnt_ff;
  // never loses arbitration, so fail stays low
  assign tx_fail = 1'b0;
  // not ready while a frame is on the wire
  assign tx_ready = run & ~busy_ff;
  // hold each frame for delay+1 cycles, then pulse success once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      cnt_ff <= 4'h0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tx_load) begin
        busy_ff <= 1'b1;
        cnt_ff <= delay;
      end else if (busy_ff && cnt_ff == 4'h0) begin
        busy_ff <= 1'b0;
        tx_done <= 1'b1;
      end else if (busy_ff) begin
        cnt_ff <= cnt_ff - 4'h1;
      end
    end
  end
endmodule

// *** tb/can_message_object_access_tb.sv ***
// self-checking bench of the message-object access block
`timescale 1ns/1ps
`include "can_moa_regs.svh"
module can_message_object_access_tb import can_moa_pkg::*; ;
  // ************
  // signals
  // ************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, tx_ready, tx_done, tx_fail, tx_load, rx_done, rx_hit, xfer_busy;
  logic [5:0] tx_obj, rx_obj;
  tx_frame_t tx_frame;
  logic rx_valid = 1'b0;
  rx_hdr_t rx_hdr = '0;
  logic run = 1'b0;
  logic [3:0] delay = 4'h0;
  logic [31:0] seed = 32'h28;
  int errors = 0;
  int comparisons = 0;
  logic [5:0] loads [$];
  tx_frame_t frames [$];
  always #5 pclk = ~pclk;
  can_message_object_access DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .tx_ready(tx_ready), .tx_done(tx_done), .tx_fail(tx_fail), .tx_load(tx_load), .tx_obj(tx_obj),
    .tx_frame(tx_frame), .rx_valid(rx_valid), .rx_hdr(rx_hdr), .rx_done(rx_done), .rx_hit(rx_hit),
    .rx_obj(rx_obj), .xfer_busy(xfer_busy));
  can_tx_shift_model shift (.pclk(pclk), .presetn(presetn), .run(run), .delay(delay), .tx_load(tx_load),
    .tx_ready(tx_ready), .tx_done(tx_done), .tx_fail(tx_fail));
  // ************
  // helpers
  // ************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // summary bit of an object
  function automatic logic [31:0] obit(input int n);
    return 32'h1 << (n - 1);
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // one apb transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // ends when pready is sampled high; if pready never comes, only the watchdog ends this wait
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, a, d, q, er);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic er;
    apb(1'b0, a, 32'h0, q, er);
  endtask
  // poll the busy bit, bounded
  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    q = 32'h8000;
    while (q[15] !== 1'b0 && n < 10) begin
      rd(`OFF_CMD_REQ, q);
      n++;
    end
    if (q[15] !== 1'b0) errors++;
  endtask
  task automatic xfer(input logic [5:0] obj);
    wr(`OFF_CMD_REQ, {26'h0, obj});
    wait_idle();
  endtask
  // raise the flags of a configured object by a control-only write
  task automatic req(input logic [5:0] obj, input logic [15:0] c);
    wr(`OFF_CMD_MASK, 32'h90);
    wr(`OFF_MSG_CTRL, {16'h0, c});
    xfer(obj);
  endtask
  // write every group of an object
  task automatic cfg(input logic [5:0] obj, input logic [15:0] a1, a2, c, m1, m2, input logic [63:0] d);
    logic [15:0] v [9];
    v = '{m1, m2, a1, a2, c, d[15:0], d[31:16], d[47:32], d[63:48]};
    wr(`OFF_CMD_MASK, 32'hf3);
    for (int i = 0; i < 9; i++) wr(8'h04 + 8'(4 * i), {16'h0, v[i]});
    xfer(obj);
  endtask
  task automatic rdback(input logic [5:0] obj, input logic [31:0] cm, output logic [15:0] v [9]);
    logic [31:0] q;
    wr(`OFF_CMD_MASK, cm);
    xfer(obj);
    for (int i = 0; i < 9; i++) begin
      rd(8'h04 + 8'(4 * i), q);
      v[i] = q[15:0];
    end
  endtask
  task automatic rx(input logic [28:0] id, input logic ext, rem, hit, input logic [5:0] obj);
    @(posedge pclk);
    rx_hdr <= '{id: id, ext: ext, remote: rem, dlc: 4'h0};
    rx_valid <= 1'b1;
    @(posedge pclk);
    rx_valid <= 1'b0;
    @(posedge pclk);
    chk("rx done", 32'h1, {31'h0, rx_done});
    chk("rx hit", {31'h0, hit}, {31'h0, rx_hit});
    chk("rx obj", {26'h0, obj}, {26'h0, rx_obj});
  endtask
  // collect every load in order
  always @(posedge pclk) begin
    if (tx_load === 1'b1) begin
      loads.push_back(tx_obj);
      frames.push_back(tx_frame);
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    errors++;
    report_and_stop();
  end
  // ************
  // scenarios
  // ************
  initial begin
    logic [31:0] q;
    logic er;
    logic [15:0] v [9];
    logic [63:0] d2;
    logic [28:0] rid;
    int n;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(`OFF_CMD_REQ, q);
    chk("crq reset", 32'h1, q);
    apb(1'b0, 8'h3c, 32'h0, q, er);
    chk("unmapped err", 32'h1, {31'h0, er});
    // two transmit objects held back, then a data-only update
    q = xs();
    rid = q[28:0];
    d2 = {xs(), xs()};
    cfg(6'h2, rid[15:0], {3'b111, rid[28:16]}, 16'h0088, 16'h0, 16'h0, d2);
    cfg(6'h3, 16'hffff, {3'b101, 11'h2a5, 2'b00}, 16'h0888, 16'h0, 16'h0, {xs(), xs()});
    req(6'h2, 16'h0188);
    req(6'h3, 16'h0988);
    q = xs();
    d2[31:0] = q;
    wr(`OFF_CMD_MASK, 32'h82);
    wr(`OFF_DATA_A_LOW, {16'h0, q[15:0]});
    wr(`OFF_DATA_A_HIGH, {16'h0, q[31:16]});
    xfer(6'h2);
    wr(`OFF_MASK_LOW, 32'h5a5a);
    rdback(6'h2, 32'h33, v);
    chk("arb high", {16'h0, 3'b111, rid[28:16]}, {16'h0, v[3]});
    chk("mask kept", 32'h5a5a, {16'h0, v[0]});
    chk("data a", d2[31:0], {v[6], v[5]});
    chk("data b", d2[63:32], {v[8], v[7]});
    rd(`OFF_TX_REQ_SUM, q);
    chk("tx pending", 32'h6, q);
    // let the shift register run until both are sent
    q = xs();
    delay <= {1'b0, q[2:0]};
    run <= 1'b1;
    n = 0;
    q = 32'h6;
    while (q !== 32'h0 && n < 40) begin
      rd(`OFF_TX_REQ_SUM, q);
      n++;
    end
    run <= 1'b0;
    chk("tx req cleared", 32'h0, q);
    chk("first load", 32'h2, {26'h0, loads[0]});
    chk("second load", 32'h3, {26'h0, loads[1]});
    chk("ext id", {3'h0, rid}, {3'h0, frames[0].id});
    chk("ext flag", 32'h1, {31'h0, frames[0].ext});
    chk("length code", 32'h8, {28'h0, frames[0].dlc});
    chk("byte order", d2[31:0], frames[0].data[31:0]);
    chk("std id", 32'h2a5, {21'h0, frames[1].id[10:0]});
    rd(`OFF_PEND_SUM, q);
    chk("tx int pend", obit(3), q);
    // pending kept without the clear bit, cleared with it
    wr(`OFF_CMD_MASK, 32'h10);
    xfer(6'h3);
    rd(`OFF_PEND_SUM, q);
    chk("pend kept", obit(3), q);
    wr(`OFF_CMD_MASK, 32'h08);
    xfer(6'h3);
    rd(`OFF_PEND_SUM, q);
    chk("pend cleared", 32'h0, q);
    cfg(6'h8, 16'h0, 16'h8000, 16'h0008, 16'h0, 16'h0, 64'h0);
    req(6'h8, 16'h8008);
    rd(`OFF_NEW_DATA_SUM, q);
    chk("new data set", obit(8), q);
    wr(`OFF_CMD_MASK, 32'h04);
    xfer(6'h8);
    rd(`OFF_NEW_DATA_SUM, q);
    chk("new data cleared", 32'h0, q);
    // busy stands two cycles after the request; a later write lands
    wr(`OFF_MASK_LOW, 32'h1111);
    wr(`OFF_CMD_REQ, 32'h5);
    @(posedge pclk);
    chk("busy", 32'h1, {31'h0, xfer_busy});
    repeat (2) @(posedge pclk);
    chk("busy done", 32'h0, {31'h0, xfer_busy});
    wr(`OFF_MASK_LOW, 32'h2222);
    rd(`OFF_MASK_LOW, q);
    chk("write after busy", 32'h2222, q);
    // acceptance scan: none, first of two, open mask, standard mask
    cfg(6'h4, 16'h0, {3'b101, 11'h123, 2'b00}, 16'h0208, 16'h0, 16'h0, 64'h0);
    cfg(6'h5, 16'h0, {3'b101, 11'h123, 2'b00}, 16'h0208, 16'h0, 16'h0, 64'h0);
    rx(29'h77, 1'b0, 1'b1, 1'b0, 6'h0);
    rx(29'h123, 1'b0, 1'b1, 1'b1, 6'h4);
    rd(`OFF_TX_REQ_SUM, q);
    chk("remote request", obit(4), q);
    cfg(6'h6, 16'h0, 16'h8000, 16'h1008, 16'h0, 16'h0, 64'h0);
    q = xs();
    rx(q[28:0], q[29], 1'b0, 1'b1, 6'h6);
    cfg(6'h1, 16'habcd, {3'b100, 11'h155, 2'b00}, 16'h1008, 16'hffff, 16'hdffc, 64'h0);
    rx(29'h155, 1'b0, 1'b0, 1'b1, 6'h1);
    rx(29'h154, 1'b0, 1'b0, 1'b1, 6'h6);
    // clock enable low freezes the scan result
    ce <= 1'b0;
    rx_valid <= 1'b1;
    @(posedge pclk);
    ce <= 1'b1;
    rx_valid <= 1'b0;
    @(posedge pclk);
    chk("frozen scan", 32'h0, {31'h0, rx_done});
    report_and_stop();
  end
endmodule
